// ==== core/i2cm_mux.sv ====
// I2C channel multiplexer or switch with stop-applied channel control
`include "i2cm_params.svh"
`timescale 1ns/100ps
`default_nettype none

module i2cm_mux
   import i2cm_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter bit IS_SWITCH = 1'b1,
   parameter logic [6:0] DEV_ADDR = `I2CM_DEF_ADDR
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic up_scl_in,
   output logic up_scl_out,
   output logic up_scl_oe,
   input wire logic up_sda_in,
   output logic up_sda_out,
   output logic up_sda_oe,
   input wire logic [NUM_CH-1:0] dn_scl_in,
   output logic [NUM_CH-1:0] dn_scl_out,
   output logic [NUM_CH-1:0] dn_scl_oe,
   input wire logic [NUM_CH-1:0] dn_sda_in,
   output logic [NUM_CH-1:0] dn_sda_out,
   output logic [NUM_CH-1:0] dn_sda_oe,
   output logic [NUM_CH-1:0] chan_en
);

   localparam int SELW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
   localparam int RAWW = 2 + 2 * NUM_CH;

   generate
      if (NUM_CH != 2 && NUM_CH != 4 && NUM_CH != 8) begin : g_bad
         $error("NUM_CH must be 2, 4 or 8");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   wire logic [RAWW-1:0] raw_in;
   logic [RAWW-1:0] sync1;
   logic [RAWW-1:0] sync2;

   assign raw_in = {dn_sda_in, dn_scl_in, up_sda_in, up_scl_in};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1 <= '1;
         sync2 <= '1;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   wire logic s_up_scl = sync2[0];
   wire logic s_up_sda = sync2[1];
   wire logic [NUM_CH-1:0] s_dn_scl = sync2[2 +: NUM_CH];
   wire logic [NUM_CH-1:0] s_dn_sda = sync2[2+NUM_CH +: NUM_CH];

   // ----------------------------------------------------------------
   // Merged bus view and line pass-through
   // ----------------------------------------------------------------
   // Commands are decoded from the wired-AND of all connected segments
   logic slave_drive;
   wire logic bus_scl = s_up_scl & (&(s_dn_scl | ~chan_en));
   wire logic bus_sda = s_up_sda & (&(s_dn_sda | ~chan_en));
   wire logic [1:0] up_low = {~s_up_sda, ~s_up_scl};
   wire logic [1:0] dn_low = {|(~s_dn_sda & chan_en),
      |(~s_dn_scl & chan_en)};
   wire logic [1:0] hold = {slave_drive, 1'b0};
   wire logic [1:0] up_oe;
   wire logic [1:0] dn_drv;

   // The first side to pull low owns the line; the guard stops our own
   // echo, seen late through the synchroniser, from being taken as a
   // new low and locking the bus.
   genvar l;
   generate
      for (l = 0; l < 2; l++) begin : g_line
         i2cm_own_e owner;
         i2cm_own_e next_owner;
         logic [2:0] guard;
         logic [2:0] next_guard;

         always_comb begin
            next_owner = owner;
            next_guard = (guard != 3'h0) ? guard - 3'h1 : 3'h0;
            case (owner)
               OWN_NONE: begin
                  if (hold[l]) begin
                     next_guard = `I2CM_GUARD_CYCLES;
                  end else if (guard == 3'h0 && up_low[l]) begin
                     next_owner = OWN_UP;
                  end else if (guard == 3'h0 && dn_low[l]) begin
                     next_owner = OWN_DOWN;
                  end
               end
               OWN_UP: begin
                  if (!up_low[l]) begin
                     next_owner = OWN_NONE;
                     next_guard = `I2CM_GUARD_CYCLES;
                  end
               end
               default: begin
                  if (!dn_low[l]) begin
                     next_owner = OWN_NONE;
                     next_guard = `I2CM_GUARD_CYCLES;
                  end
               end
            endcase
         end

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               owner <= OWN_NONE;
               guard <= 3'h0;
            end else begin
               owner <= next_owner;
               guard <= next_guard;
            end
         end

         assign up_oe[l] = (owner == OWN_DOWN) | hold[l];
         assign dn_drv[l] = (owner == OWN_UP) | hold[l];
      end
   endgenerate

   // Open-drain: only the enables move, the driven level is always low
   assign up_scl_out = 1'b0;
   assign up_sda_out = 1'b0;
   assign dn_scl_out = '0;
   assign dn_sda_out = '0;
   assign up_scl_oe = up_oe[0];
   assign up_sda_oe = up_oe[1];
   assign dn_scl_oe = chan_en & {NUM_CH{dn_drv[0]}};
   assign dn_sda_oe = chan_en & {NUM_CH{dn_drv[1]}};

   // ----------------------------------------------------------------
   // Control byte target
   // ----------------------------------------------------------------
   logic bus_scl_d;
   logic bus_sda_d;
   i2cm_slv_e state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic rw;
   logic nack;
   logic [7:0] pending;
   logic got_write;
   logic [7:0] ctrl;

   wire logic scl_rise = bus_scl & ~bus_scl_d;
   wire logic scl_fall = ~bus_scl & bus_scl_d;
   wire logic start_det = bus_scl & bus_scl_d & bus_sda_d & ~bus_sda;
   wire logic stop_det = bus_scl & bus_scl_d & ~bus_sda_d & bus_sda;
   wire logic byte_done = (bit_cnt == 4'h8);
   wire logic addr_hit = (shift[7:1] == DEV_ADDR);

   // Channel decode of a control byte
   wire logic [NUM_CH-1:0] mux_dec;
   wire logic [NUM_CH-1:0] next_en;
   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_dec
         assign mux_dec[c] = pending[`I2CM_MUX_EN_BIT]
            & (pending[SELW-1:0] == SELW'(c));
      end
   endgenerate
   // Out-of-range bits of a switch byte are simply ignored
   assign next_en = IS_SWITCH ? pending[NUM_CH-1:0] : mux_dec;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bus_scl_d <= 1'b1;
         bus_sda_d <= 1'b1;
      end else begin
         bus_scl_d <= bus_scl;
         bus_sda_d <= bus_sda;
      end
   end

   // Applied setting changes only here, so a byte that is written
   // mid-transfer never cuts the segment the master is talking on
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= `I2CM_CTRL_RESET;
         chan_en <= '0;
      end else if (stop_det && got_write) begin
         ctrl <= pending;
         chan_en <= next_en;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= SL_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         rw <= 1'b0;
         nack <= 1'b0;
         pending <= `I2CM_CTRL_RESET;
         got_write <= 1'b0;
         slave_drive <= 1'b0;
      end else if (stop_det) begin
         state <= SL_IDLE;
         got_write <= 1'b0;
         slave_drive <= 1'b0;
      end else if (start_det) begin
         state <= SL_ADDR;
         bit_cnt <= 4'h0;
         slave_drive <= 1'b0;
      end else begin
         case (state)
            SL_ADDR, SL_WDATA: begin
               if (scl_rise && !byte_done) begin
                  shift <= {shift[6:0], bus_sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && byte_done) begin
                  bit_cnt <= 4'h0;
                  if (state == SL_WDATA) begin
                     pending <= shift;
                     got_write <= 1'b1;
                     state <= SL_ACK_DATA;
                     slave_drive <= 1'b1;
                  end else if (addr_hit) begin
                     rw <= shift[0];
                     state <= SL_ACK_ADDR;
                     slave_drive <= 1'b1;
                  end else begin
                     state <= SL_IDLE;
                  end
               end
            end
            SL_ACK_ADDR, SL_ACK_DATA: begin
               if (scl_fall) begin
                  if (state == SL_ACK_ADDR && rw) begin
                     shift <= ctrl;
                     slave_drive <= ~ctrl[7];
                     bit_cnt <= 4'h1;
                     state <= SL_RDATA;
                  end else begin
                     slave_drive <= 1'b0;
                     state <= SL_WDATA;
                  end
               end
            end
            SL_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt == 4'h8) begin
                     slave_drive <= 1'b0;
                     state <= SL_RACK;
                  end else begin
                     shift <= {shift[6:0], 1'b0};
                     slave_drive <= ~shift[6];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            SL_RACK: begin
               if (scl_rise) begin
                  nack <= bus_sda;
               end else if (scl_fall) begin
                  if (nack) begin
                     state <= SL_IDLE;
                  end else begin
                     shift <= ctrl;
                     slave_drive <= ~ctrl[7];
                     bit_cnt <= 4'h1;
                     state <= SL_RDATA;
                  end
               end
            end
            default: begin
               slave_drive <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ==== core/i2cm_params.svh ====
// Constants for the I2C channel multiplexer and switch
`ifndef I2CM_PARAMS_SVH
`define I2CM_PARAMS_SVH

// Control byte value after reset: every channel closed
`define I2CM_CTRL_RESET 8'h00
// Bit of the control byte that enables the selected mux channel
`define I2CM_MUX_EN_BIT 3
// Cycles a line is left alone after a drive ends (covers sync delay)
`define I2CM_GUARD_CYCLES 3'h3
// Neutral target address, value is arbitrary
`define I2CM_DEF_ADDR 7'h3a

`endif

// ==== core/i2cm_pkg.sv ====
// Types shared by the I2C channel multiplexer and switch
package i2cm_pkg;

   // Which side currently holds a passed-through line low
   typedef enum logic [1:0] {
      OWN_NONE,
      OWN_UP,
      OWN_DOWN
   } i2cm_own_e;

   // Control-byte target states
   typedef enum logic [2:0] {
      SL_IDLE,
      SL_ADDR,
      SL_ACK_ADDR,
      SL_WDATA,
      SL_ACK_DATA,
      SL_RDATA,
      SL_RACK
   } i2cm_slv_e;

endpackage

// ==== verification/i2cm_mux_sva.sv ====
// Concurrent checks for the I2C channel mux and switch
`timescale 1ns/100ps
`default_nettype none
module i2cm_mux_sva #(
   parameter int NUM_CH = 4,
   parameter bit IS_SWITCH = 1'b1
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic up_scl_in,
   input wire logic up_sda_in,
   input wire logic up_scl_oe,
   input wire logic up_sda_oe,
   input wire logic [NUM_CH-1:0] dn_scl_oe,
   input wire logic [NUM_CH-1:0] dn_sda_oe,
   input wire logic [NUM_CH-1:0] chan_en
);
   logic scl_q;
   logic sda_q;
   logic [3:0] stop_age;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= up_scl_in;
         sda_q <= up_sda_in;
      end
   end
   // Saturates so an old stop never aliases a new one
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stop_age <= 4'hf;
      end else if (scl_q && up_scl_in && !sda_q && up_sda_in) begin
         stop_age <= 4'h0;
      end else if (stop_age != 4'hf) begin
         stop_age <= stop_age + 4'h1;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   chk_mux_one_hot: assert property (
      !IS_SWITCH |-> $onehot0(chan_en)) else $error("two mux channels on");
   chk_stop_apply: assert property (
      $changed(chan_en) |-> stop_age inside {[1:8]})
      else $error("channels changed away from stop");
   chk_scl_low_pass: assert property (
      (!up_scl_oe && !up_scl_in) [*8] |-> dn_scl_oe == chan_en)
      else $error("scl low not passed down");
   chk_sda_low_pass: assert property (
      (!up_sda_oe && !up_sda_in) [*8] |-> dn_sda_oe == chan_en)
      else $error("sda low not passed down");
   chk_scl_release: assert property (
      up_scl_in [*8] |-> dn_scl_oe == '0) else $error("scl held down");
   chk_sda_release: assert property (
      up_sda_in [*8] |-> dn_sda_oe == '0) else $error("sda held down");
   chk_reset_clear: assert property (
      $rose(resetn) |-> chan_en == '0 && !up_scl_oe && !up_sda_oe)
      else $error("not cleared by reset");
   chk_closed_quiet: assert property (
      ((dn_scl_oe | dn_sda_oe) & ~chan_en & ~$past(chan_en)) == '0)
      else $error("closed channel driven");
endmodule
bind i2cm_mux i2cm_mux_sva #(.NUM_CH(NUM_CH), .IS_SWITCH(IS_SWITCH)) u_sva (
   .mclk(mclk), .resetn(resetn), .up_scl_in(up_scl_in),
   .up_sda_in(up_sda_in), .up_scl_oe(up_scl_oe), .up_sda_oe(up_sda_oe),
   .dn_scl_oe(dn_scl_oe), .dn_sda_oe(dn_sda_oe), .chan_en(chan_en));
`default_nettype wire

// ==== verification/i2cm_bus_model.sv ====
// Wired-AND bus with a bit-level I2C master for the mux bench
`timescale 1ns/100ps
`default_nettype none
module i2cm_bus_model #(
   parameter int N = 4
) (
   input wire logic mclk,
   input wire logic dn_mode,
   input wire logic [1:0] up_scl_oe,
   input wire logic [1:0] up_sda_oe,
   input wire logic [N-1:0] dn_scl_oe,
   input wire logic [N-1:0] dn_sda_oe,
   output logic up_scl,
   output logic up_sda,
   output logic [N-1:0] dn_scl,
   output logic [N-1:0] dn_sda
);
   logic m_scl = 1'b1;
   logic m_sda = 1'b1;
   // Master sits upstream or on channel 0; pull-ups elsewhere
   assign up_scl = (dn_mode | m_scl) & ~|up_scl_oe;
   assign up_sda = (dn_mode | m_sda) & ~|up_sda_oe;
   assign dn_scl = ~dn_scl_oe & {{(N-1){1'b1}}, ~dn_mode | m_scl};
   assign dn_sda = ~dn_sda_oe & {{(N-1){1'b1}}, ~dn_mode | m_sda};
   // Phases of 8 cycles leave room for the 2-flop sync
   task automatic half();
      repeat (8) @(posedge mclk);
      #1;
   endtask
   task automatic start();
      m_sda = 1'b0;
      half();
      m_scl = 1'b0;
      half();
   endtask
   task automatic stop();
      m_sda = 1'b0;
      half();
      m_scl = 1'b1;
      half();
      m_sda = 1'b1;
      half();
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         m_sda = (i == 0) ? 1'b1 : b[i-1];
         half();
         m_scl = 1'b1;
         half();
         ack = dn_mode ? dn_sda[0] : up_sda;
         m_scl = 1'b0;
         half();
      end
   endtask
   // Releases SDA for eight bits, then answers with a NACK
   task automatic get(output logic [7:0] b);
      for (int i = 8; i >= 0; i--) begin
         m_sda = 1'b1;
         half();
         m_scl = 1'b1;
         half();
         if (i > 0) begin
            b[i-1] = dn_mode ? dn_sda[0] : up_sda;
         end
         m_scl = 1'b0;
         half();
      end
   endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the I2C channel mux and switch
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic dn_mode = 1'b0;
   logic up_scl, up_sda, ack;
   logic [1:0] uso, udo;
   logic [3:0] dso, ddo, dscl, dsda, en_s, en_m, ps, pm, bso, bdo;
   logic [7:0] rb;
   int bad_count = 0;
   int total_checks = 0;
   // Rows: target address, control byte, switch and mux enables
   localparam logic [22:0] ROWS [7] = '{{7'h3a, 8'h05, 4'h5, 4'h0},
      {7'h3b, 8'h0b, 4'h5, 4'h8}, {7'h3a, 8'hf3, 4'h3, 4'h8},
      {7'h3b, 8'h0e, 4'h3, 4'h4}, {7'h3a, 8'h0f, 4'hf, 4'h4},
      {7'h3b, 8'h07, 4'hf, 4'h0}, {7'h3a, 8'h00, 4'h0, 4'h0}};
   always #5 mclk = ~mclk;
   i2cm_mux u_i2cm_mux (
      .mclk(mclk), .resetn(resetn), .up_scl_in(up_scl), .up_scl_out(),
      .up_scl_oe(uso[0]), .up_sda_in(up_sda), .up_sda_out(),
      .up_sda_oe(udo[0]), .dn_scl_in(dscl), .dn_scl_out(), .dn_scl_oe(dso),
      .dn_sda_in(dsda), .dn_sda_out(), .dn_sda_oe(ddo), .chan_en(en_s));
   // Mux channels are pulled-up wires that only the mux itself pulls low
   i2cm_mux #(.IS_SWITCH(1'b0), .DEV_ADDR(7'h3b)) u_i2cm_mux_b (
      .mclk(mclk), .resetn(resetn), .up_scl_in(up_scl), .up_scl_out(),
      .up_scl_oe(uso[1]), .up_sda_in(up_sda), .up_sda_out(),
      .up_sda_oe(udo[1]), .dn_scl_in(~bso), .dn_scl_out(), .dn_scl_oe(bso),
      .dn_sda_in(~bdo), .dn_sda_out(), .dn_sda_oe(bdo), .chan_en(en_m));
   i2cm_bus_model u_i2cm_bus_model (
      .mclk(mclk), .dn_mode(dn_mode), .up_scl_oe(uso), .up_sda_oe(udo),
      .dn_scl_oe(dso), .dn_sda_oe(ddo), .up_scl(up_scl), .up_sda(up_sda),
      .dn_scl(dscl), .dn_sda(dsda));
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h not %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Leaves the bus before stop so held settings can be seen
   task automatic wr(input logic [6:0] ad, input logic [7:0] d);
      logic a1;
      logic a2;
      u_i2cm_bus_model.start();
      u_i2cm_bus_model.put({ad, 1'b0}, a1);
      u_i2cm_bus_model.put(d, a2);
      ack = a1 | a2;
   endtask
   // Whole read frame: address, one byte back, NACK, stop
   task automatic rd(input logic [6:0] ad, output logic [7:0] d);
      logic a1;
      u_i2cm_bus_model.start();
      u_i2cm_bus_model.put({ad, 1'b1}, a1);
      u_i2cm_bus_model.get(d);
      u_i2cm_bus_model.stop();
      ack = a1;
   endtask
   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge mclk);
      #1 resetn = 1'b1;
      check(en_s, 4'h0);
      check(en_m, 4'h0);
      $display("Reset test done");
      repeat (3) @(posedge mclk);
      #1;
      ps = 4'h0;
      pm = 4'h0;
      foreach (ROWS[i]) begin
         wr(ROWS[i][22:16], ROWS[i][15:8]);
         check({3'h0, ack}, 4'h0);
         check(en_s, ps);
         check(en_m, pm);
         u_i2cm_bus_model.stop();
         ps = ROWS[i][7:4];
         pm = ROWS[i][3:0];
         check(en_s, ps);
         check(en_m, pm);
      end
      $display("Table rows done");
      wr(7'h11, 8'h0f);
      u_i2cm_bus_model.stop();
      check({3'h0, ack}, 4'h1);
      check(en_s, 4'h0);
      $display("Foreign address done");
      wr(7'h3a, 8'h01);
      u_i2cm_bus_model.stop();
      dn_mode = 1'b1;
      wr(7'h3a, 8'h06);
      check({3'h0, ack}, 4'h0);
      check(en_s, 4'h1);
      u_i2cm_bus_model.stop();
      check(en_s, 4'h6);
      dn_mode = 1'b0;
      $display("Downstream command done");
      rd(7'h3a, rb);
      check({3'h0, ack}, 4'h0);
      check(rb[7:4], 4'h0);
      check(rb[3:0], 4'h6);
      check(en_s, 4'h6);
      $display("Read-back done");
      @(posedge mclk);
      #1 resetn = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      check(en_s, 4'h0);
      resetn = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      check(en_s, 4'h0);
      $display("Mid-run reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
